// ### hw/timebase_rtc.v
// Time-base unit with low-power mode control and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "timebase_defines.vh"
module timebase_rtc #(
    parameter [17:0] PERIOD_0 = `TB_PERIOD_0,
    parameter [17:0] PERIOD_1 = `TB_PERIOD_1,
    parameter [17:0] PERIOD_2 = `TB_PERIOD_2,
    parameter [17:0] PERIOD_3 = `TB_PERIOD_3
) (
    input  wire       core_clk_in,
    input  wire       nrst_in,
    input  wire [2:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       wr_in,
    input  wire       rd_in,
    output reg  [7:0] rdata_out,
    input  wire       cpu_mask_in,
    input  wire       halt_req_in,
    input  wire       awu_halt_req_in,
    input  wire       wait_req_in,
    input  wire       other_wake_in,
    output reg        irq_out,
    output reg        wake_out,
    output reg  [2:0] mode_out,
    output reg        tick_out
);
    localparam [2:0] ST_RUN      = 3'h0;
    localparam [2:0] ST_WAIT     = 3'h1;
    localparam [2:0] ST_ACT_HALT = 3'h2;
    localparam [2:0] ST_HALT     = 3'h3;
    localparam [2:0] ST_AWU_HALT = 3'h4;

    reg  [2:0]           state_r;
    reg  [2:0]           state_nxt;
    reg  [1:0]           sel_r;
    reg  [1:0]           sel_nxt;
    reg  [1:0]           sel_active_r;
    reg  [1:0]           sel_active_nxt;
    reg                  enable_r;
    reg                  enable_nxt;
    reg                  flag_r;
    reg                  flag_nxt;
    reg                  irq_nxt;
    reg                  wake_nxt;
    reg  [7:0]           rdata_nxt;
    reg  [17:0]          period;
    wire                 div_tick;
    wire [17:0]          div_count;
    wire                 frozen;
    wire                 regs_hold;
    wire                 irq_req;
    wire                 wr_ok;
    wire                 clear_hit;

    // Counter stops only in plain and auto-wakeup halt
    assign frozen = (state_r == ST_HALT) ||
                    (state_r == ST_AWU_HALT);

    // Registers hold in every halt flavour
    assign regs_hold = frozen || (state_r == ST_ACT_HALT);

    assign wr_ok = wr_in && !regs_hold;

    // Request from the time-base event
    assign irq_req = flag_r && enable_r && !cpu_mask_in;

    assign clear_hit = wr_ok && (addr_in == `TB_REG_CLEAR) &&
                       wdata_in[`TB_FLAG_BIT];

    // Period lookup from the active selection
    always @* begin
        case (sel_active_r)
            2'h0: period = PERIOD_0;
            2'h1: period = PERIOD_1;
            2'h2: period = PERIOD_2;
            default: period = PERIOD_3;
        endcase
    end

    timebase_divider #(
        .W (`TB_CNT_W)
    ) u_div (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .run_in      (!frozen),
        .period_in   (period),
        .tick_out    (div_tick),
        .count_out   (div_count)
    );

    // Power mode sequencing
    always @* begin
        state_nxt = state_r;
        wake_nxt  = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (awu_halt_req_in) begin
                    state_nxt = ST_AWU_HALT;
                end else if (halt_req_in) begin
                    if (enable_r) begin
                        state_nxt = ST_ACT_HALT;
                    end else begin
                        state_nxt = ST_HALT;
                    end
                end else if (wait_req_in) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (irq_req || other_wake_in) begin
                    state_nxt = ST_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            ST_ACT_HALT: begin
                if (irq_req || other_wake_in) begin
                    state_nxt = ST_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            ST_HALT: begin
                if (other_wake_in) begin
                    state_nxt = ST_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            ST_AWU_HALT: begin
                if (other_wake_in) begin
                    state_nxt = ST_RUN;
                    wake_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // Software-written control fields
    always @* begin
        sel_nxt    = sel_r;
        enable_nxt = enable_r;
        if (wr_ok) begin
            if (addr_in == `TB_REG_CTRL) begin
                sel_nxt    = wdata_in[`TB_SEL_HI:`TB_SEL_LO];
                enable_nxt = wdata_in[`TB_ENABLE_BIT];
            end else if (addr_in == `TB_REG_IRQ_EN) begin
                enable_nxt = wdata_in[`TB_FLAG_BIT];
            end
        end
    end

    // Selection moves to the divider only at a period end
    always @* begin
        sel_active_nxt = sel_active_r;
        if (div_tick) begin
            sel_active_nxt = sel_r;
        end
    end

    // Sticky event flag, set wins over clear
    always @* begin
        flag_nxt = flag_r;
        if (clear_hit) begin
            flag_nxt = 1'b0;
        end
        if (div_tick) begin
            flag_nxt = 1'b1;
        end
    end

    // Level request follows the next flag and enable
    always @* begin
        irq_nxt = flag_nxt && enable_nxt && !cpu_mask_in;
    end

    // Read data for the cycle after the strobe
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_in) begin
            if (addr_in == `TB_REG_CTRL) begin
                rdata_nxt[`TB_SEL_HI:`TB_SEL_LO] = sel_r;
                rdata_nxt[`TB_ENABLE_BIT]        = enable_r;
                rdata_nxt[`TB_FLAG_BIT]          = flag_r;
            end else if (addr_in == `TB_REG_STATUS) begin
                rdata_nxt[`TB_FLAG_BIT] = flag_r;
            end else if (addr_in == `TB_REG_IRQ_EN) begin
                rdata_nxt[`TB_FLAG_BIT] = enable_r;
            end else if (addr_in == `TB_REG_CNT_LO) begin
                rdata_nxt = div_count[7:0];
            end else if (addr_in == `TB_REG_CNT_MID) begin
                rdata_nxt = div_count[15:8];
            end else if (addr_in == `TB_REG_CNT_HI) begin
                rdata_nxt = {6'h00, div_count[17:16]};
            end else if (addr_in == `TB_REG_MODE) begin
                rdata_nxt = {3'h0, sel_active_r, state_r};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r      <= ST_RUN;
            sel_r        <= `TB_SEL_RST;
            sel_active_r <= `TB_SEL_RST;
            enable_r     <= `TB_ENABLE_RST;
            flag_r       <= `TB_FLAG_RST;
            irq_out      <= 1'b0;
            wake_out     <= 1'b0;
            mode_out     <= ST_RUN;
            tick_out     <= 1'b0;
            rdata_out    <= 8'h00;
        end else begin
            state_r      <= state_nxt;
            sel_r        <= sel_nxt;
            sel_active_r <= sel_active_nxt;
            enable_r     <= enable_nxt;
            flag_r       <= flag_nxt;
            irq_out      <= irq_nxt;
            wake_out     <= wake_nxt;
            mode_out     <= state_nxt;
            tick_out     <= div_tick;
            rdata_out    <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ### hw/timebase_defines.vh
// Constants of the time-base and real-time-clock block
// What this block does
// - Counter and interrupt keep running during WAIT
// - ACTIVE HALT: counter runs, registers hold
// - HALT and auto-wakeup HALT freeze everything
// - Resume only after another wake source exits
// - Request needs enable set and CPU unmasked
// - Time-base wakes WAIT and ACTIVE HALT only
// - One overflow event with flag and enable
// - Halt with enable set means ACTIVE HALT
// - Select picks 16000/32000/80000/200000 cycle period
// - New selection applies at current period end
`ifndef TIMEBASE_DEFINES_VH
`define TIMEBASE_DEFINES_VH

// Register indices on the 3-bit address port
`define TB_REG_CTRL     3'h0
`define TB_REG_STATUS   3'h1
`define TB_REG_CLEAR    3'h2
`define TB_REG_IRQ_EN   3'h3
`define TB_REG_CNT_LO   3'h4
`define TB_REG_CNT_MID  3'h5
`define TB_REG_CNT_HI   3'h6
`define TB_REG_MODE     3'h7

// Field positions
`define TB_FLAG_BIT     0
`define TB_ENABLE_BIT   1
`define TB_SEL_LO       2
`define TB_SEL_HI       3

// Reset values
`define TB_SEL_RST      2'h0
`define TB_ENABLE_RST   1'b0
`define TB_FLAG_RST     1'b0

// Divider periods in oscillator cycles
`define TB_PERIOD_0     18'h03e80
`define TB_PERIOD_1     18'h07d00
`define TB_PERIOD_2     18'h13880
`define TB_PERIOD_3     18'h30d40
`define TB_CNT_W        18

`endif

// ### hw/timebase_divider.v
// Programmable period divider with an end-of-period pulse
`timescale 1ns/1ps
`default_nettype none
module timebase_divider #(
    parameter W = 18
) (
    input  wire         core_clk_in,
    input  wire         nrst_in,
    input  wire         run_in,
    input  wire [W-1:0] period_in,
    output reg          tick_out,
    output reg  [W-1:0] count_out
);
    reg [W-1:0] count_nxt;
    reg         tick_nxt;
    wire        last;

    assign last = (count_out == period_in - {{(W-1){1'b0}}, 1'b1});

    always @* begin
        count_nxt = count_out;
        tick_nxt  = 1'b0;
        if (run_in) begin
            if (last) begin
                count_nxt = {W{1'b0}};
                tick_nxt  = 1'b1;
            end else begin
                count_nxt = count_out + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_out <= {W{1'b0}};
            tick_out  <= 1'b0;
        end else begin
            count_out <= count_nxt;
            tick_out  <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// ### bench/timebase_rtc_asserts.sv
// Port-level checks of the time-base block
`timescale 1ns/1ps
`default_nettype none
module timebase_rtc_asserts #(
    parameter [17:0] PERIOD_0 = 18'h03e80,
    parameter [17:0] PERIOD_1 = 18'h07d00,
    parameter [17:0] PERIOD_2 = 18'h13880,
    parameter [17:0] PERIOD_3 = 18'h30d40
) (
    input wire logic       core_clk_in,
    input wire logic       nrst_in,
    input wire logic       wr_in,
    input wire logic       cpu_mask_in,
    input wire logic       other_wake_in,
    input wire logic       irq_out,
    input wire logic       wake_out,
    input wire logic [2:0] mode_out,
    input wire logic       tick_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_irq_gate; irq_out |-> !$past(cpu_mask_in); endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
    property p_irq_hold; irq_out && !cpu_mask_in && !wr_in |=> irq_out; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_tick_space; tick_out |=> !tick_out [*7]; endproperty
    a_tick_space: assert property (p_tick_space) else $error("tick too soon");
    property p_halt_frozen; (mode_out >= 3'h3) [*4] |-> !tick_out; endproperty
    a_halt_frozen: assert property (p_halt_frozen) else $error("tick in halt");
    property p_halt_exit;
        $past(mode_out) >= 3'h3 && mode_out == 3'h0 |->
            $past(other_wake_in) || $past(other_wake_in, 2);
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("bad halt exit");
    property p_wake_pulse; wake_out |-> mode_out == 3'h0 && $past(mode_out) != 3'h0; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("stray wake");
    property p_wait_exit; mode_out == 3'h1 && irq_out |-> ##[0:2] mode_out == 3'h0; endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("no wait exit");
    property p_ahalt_exit; mode_out == 3'h2 && irq_out |-> ##[0:2] mode_out == 3'h0; endproperty
    a_ahalt_exit: assert property (p_ahalt_exit) else $error("no halt exit");
endmodule
bind timebase_rtc timebase_rtc_asserts #(.PERIOD_0(PERIOD_0), .PERIOD_1(PERIOD_1),
    .PERIOD_2(PERIOD_2), .PERIOD_3(PERIOD_3)) u_chk (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .wr_in(wr_in), .cpu_mask_in(cpu_mask_in),
    .other_wake_in(other_wake_in), .irq_out(irq_out), .wake_out(wake_out),
    .mode_out(mode_out), .tick_out(tick_out));
`default_nettype wire

// ### bench/cpu_model.sv
// Behavioural CPU core: interrupt mask, power requests, other wake source
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic clk_in,
    output logic      mask_out,
    output logic      halt_out,
    output logic      awu_out,
    output logic      wait_out,
    output logic      wake_out
);
    initial {mask_out, halt_out, awu_out, wait_out, wake_out} = 5'h00;
    // One-cycle pulse: 0 halt, 1 auto-wakeup halt, 2 wait, 3 other wake
    task pulse(input int k);
        @(posedge clk_in);
        {wake_out, wait_out, awu_out, halt_out} <= 4'h1 << k;
        @(posedge clk_in);
        {wake_out, wait_out, awu_out, halt_out} <= 4'h0;
    endtask
    task set_mask(input logic m);
        @(posedge clk_in);
        mask_out <= m;
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench of the time-base block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module tb;
    logic       clk, nrst, wr, rd, mask, hq, aq, wq, ow, irq, wk, tk;
    logic [2:0] addr, mode;
    logic [7:0] wd, rdv, rv;
    int         fail_count = 0, comparisons = 0, cyc = 0, t0, t1, t2, old;
    int         per [4] = '{8, 12, 16, 20};
    timebase_rtc #(.PERIOD_0(18'h8), .PERIOD_1(18'hc), .PERIOD_2(18'h10), .PERIOD_3(18'h14)) DUT (
        .core_clk_in(clk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdv), .cpu_mask_in(mask), .halt_req_in(hq),
        .awu_halt_req_in(aq), .wait_req_in(wq), .other_wake_in(ow), .irq_out(irq),
        .wake_out(wk), .mode_out(mode), .tick_out(tk));
    cpu_model cpu (.clk_in(clk), .mask_out(mask), .halt_out(hq), .awu_out(aq),
        .wait_out(wq), .wake_out(ow));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task give_verdict;
        $display("checks %0d failures %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdv;
    endtask
    // Wait for wake_out (w=1) or tick_out (w=0), return cycle number
    task wt(input logic w, output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((w ? wk : tk) !== 1'b1 && n < 300);
        t = cyc;
        if (n >= 300) begin
            fail_count++;
            give_verdict();
        end
    endtask
    initial begin
        {nrst, wr, rd, addr, wd} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(3'h0);
        `CHK("ctrl_rst", 8'h00, rv)
        old = per[0];
        for (int c = 0; c < 4; c++) begin
            wt(0, t0);
            wr_reg(3'h0, 8'(c << 2));
            wt(0, t1);
            wt(0, t2);
            `CHK("gap_old", old, t1 - t0)
            `CHK("gap_new", per[c], t2 - t1)
            old = per[c];
        end
        $display("test periods done");
        cpu.set_mask(1'b1);
        wr_reg(3'h0, 8'h0e);
        wt(0, t0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq_masked", 1'b0, irq)
        rd_reg(3'h1);
        `CHK("status", 8'h01, rv)
        rd_reg(3'h3);
        `CHK("irq_en", 8'h01, rv)
        cpu.set_mask(1'b0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq_on", 1'b1, irq)
        wr_reg(3'h2, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq_off", 1'b0, irq)
        rd_reg(3'h2);
        `CHK("clear_rd", 8'h00, rv)
        $display("test interrupt done");
        cpu.pulse(0);
        #1;
        `CHK("ahalt", 3'h2, mode)
        wt(1, t0);
        `CHK("ahalt_exit", 3'h0, mode)
        wr_reg(3'h2, 8'h01);
        wr_reg(3'h0, 8'h0c);
        cpu.pulse(0);
        #1;
        `CHK("halt", 3'h3, mode)
        rd_reg(3'h4);
        t0 = rv;
        repeat (40) @(posedge clk);
        rd_reg(3'h4);
        `CHK("frozen_cnt", t0, int'(rv))
        cpu.pulse(3);
        #1;
        `CHK("halt_wake", 1'b1, wk)
        `CHK("halt_exit", 3'h0, mode)
        wr_reg(3'h0, 8'h0e);
        wt(0, t0);
        wr_reg(3'h2, 8'h01);
        cpu.pulse(2);
        #1;
        `CHK("wait", 3'h1, mode)
        wt(1, t0);
        `CHK("wait_exit", 3'h0, mode)
        cpu.pulse(1);
        repeat (40) @(posedge clk);
        #1;
        `CHK("awu_hold", 3'h4, mode)
        cpu.pulse(3);
        #1;
        `CHK("awu_wake", 1'b1, wk)
        `CHK("awu_exit", 3'h0, mode)
        $display("test power modes done");
        give_verdict();
    end
endmodule
`default_nettype wire
